// [logic/cs1_pkg.sv]
// Constants for the contactless status-one register bank.
// Assumes an APB slave with 32-bit data, one word per register.
package cs1_pkg;
  localparam logic [7:0] ADDR_STATUS = 8'h00;
  localparam logic [7:0] ADDR_COMM_EN = 8'h04;
  localparam logic [7:0] ADDR_MISC_EN = 8'h08;
  localparam logic [7:0] ADDR_CPU_EN = 8'h0c;
  localparam logic [7:0] ADDR_THRESHOLD = 8'h10;
  localparam logic [7:0] ADDR_IRQ_STATUS = 8'h14;
  localparam logic [7:0] ADDR_IRQ_CLEAR = 8'h18;
  localparam logic [7:0] ADDR_IRQ_ENABLE = 8'h1c;
  localparam int BIT_GRP_ONE = 7;
  localparam int BIT_CRC_GOOD = 6;
  localparam int BIT_CRC_DONE = 5;
  localparam int BIT_GRP_ZERO = 4;
  localparam int BIT_TIMER = 3;
  localparam int BIT_FIELD = 2;
  localparam int BIT_NEAR_FULL = 1;
  localparam int BIT_NEAR_EMPTY = 0;
  localparam int CPU_EN_GRP_ONE = 2;
  localparam int CPU_EN_GRP_ZERO = 3;
  localparam int EV_GRP_ONE = 0;
  localparam int EV_GRP_ZERO = 1;
  localparam int EV_CRC_DONE = 2;
  localparam int EV_FIELD_ON = 3;
  localparam int EV_FIELD_OFF = 4;
  localparam int EV_W = 5;
  localparam int FIFO_DEPTH = 64;
  localparam int FILL_W = 7;
  localparam int THR_W = 6;
  localparam logic [7:0] STATUS_RESET = 8'h21;
  localparam logic [7:0] CPU_EN_RESET = 8'h00;
  localparam logic [5:0] THR_RESET = 6'h08;
endpackage : cs1_pkg

// [logic/cs1_sync3.sv]
// Three-stage synchroniser for one pin level.
// Assumes the pin is asynchronous to pclk.
`timescale 1ns/1ps
`default_nettype none
module cs1_sync3 (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic pin,
  output logic level
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic q;
  } cs1_sync_t;
  cs1_sync_t s;
  cs1_sync_t next_s;
  always_comb begin
    next_s = s;
    next_s.s1 = pin;
    next_s.s2 = s.s1;
    next_s.s3 = s.s2;
    // A change counts once the second and third stages agree.
    if (s.s2 == s.s3) begin
      next_s.q = s.s3;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end
  assign level = s.q;
endmodule : cs1_sync3
`default_nettype wire

// [logic/cs1_attn.sv]
// Attention summary for one interrupt group.
// Assumes pending and enable flags come from logic on the same clock.
`timescale 1ns/1ps
`default_nettype none
module cs1_attn #(
  parameter logic [7:0] COMM_MASK = 8'hff,
  parameter logic [7:0] MISC_MASK = 8'hff
) (
  input wire logic [7:0] comm_pending,
  input wire logic [7:0] comm_enable,
  input wire logic [7:0] misc_pending,
  input wire logic [7:0] misc_enable,
  output logic summary
);
  // Any member source that is both pending and enabled asks for attention.
  assign summary = |(comm_pending & comm_enable & COMM_MASK) | |(misc_pending & misc_enable & MISC_MASK);
endmodule : cs1_attn
`default_nettype wire

// [logic/cs1_status.sv]
// Status-one register bank with APB slave, enables and interrupt status.
// Assumes one clock, pclk, and a field detector pin from outside the domain.
`timescale 1ns/1ps
`default_nettype none
module cs1_status #(
  parameter logic [7:0] GRP_ONE_COMM_MASK = 8'h0f,
  parameter logic [7:0] GRP_ONE_MISC_MASK = 8'h0f,
  parameter logic [7:0] GRP_ZERO_COMM_MASK = 8'hf0,
  parameter logic [7:0] GRP_ZERO_MISC_MASK = 8'hf0,
  parameter int FIFO_DEPTH = cs1_pkg::FIFO_DEPTH
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [7:0] comm_irq_pending,
  input wire logic [7:0] misc_irq_pending,
  input wire logic crc_busy,
  input wire logic crc_finish,
  input wire logic crc_standalone,
  input wire logic crc_result_zero,
  input wire logic timer_enable,
  input wire logic timer_gate,
  input wire logic field_pin,
  input wire logic [6:0] fifo_fill_count,
  output logic cpu_irq_group_one,
  output logic cpu_irq_group_zero,
  output logic irq
);
  generate
    if (FIFO_DEPTH < 2 || FIFO_DEPTH > 64) begin : g_bad_depth
      $error("FIFO_DEPTH must lie between 2 and 64.");
    end
  endgenerate

  localparam logic [7:0] DEPTH8 = 8'(FIFO_DEPTH);

  typedef struct packed {
    logic [7:0] comm_en;
    logic [7:0] misc_en;
    logic [7:0] cpu_en;
    logic [5:0] thr;
    logic [4:0] irq_sts;
    logic [4:0] irq_en;
    logic crc_good;
    logic crc_done;
    logic one_d;
    logic zero_d;
    logic field_d;
    logic up;
    logic [7:0] status;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic irq;
    logic cpu_one;
    logic cpu_zero;
  } cs1_state_t;

  cs1_state_t s;
  cs1_state_t next_s;

  logic one_sum;
  logic zero_sum;
  logic field_q;
  logic near_full;
  logic near_empty;
  logic setup;
  logic wr;
  logic [7:0] live;
  logic [4:0] events;
  logic [7:0] wbyte;

  cs1_attn #(
    .COMM_MASK(GRP_ONE_COMM_MASK),
    .MISC_MASK(GRP_ONE_MISC_MASK)
  ) u_attn_one (
    .comm_pending(comm_irq_pending),
    .comm_enable(s.comm_en),
    .misc_pending(misc_irq_pending),
    .misc_enable(s.misc_en),
    .summary(one_sum)
  );

  cs1_attn #(
    .COMM_MASK(GRP_ZERO_COMM_MASK),
    .MISC_MASK(GRP_ZERO_MISC_MASK)
  ) u_attn_zero (
    .comm_pending(comm_irq_pending),
    .comm_enable(s.comm_en),
    .misc_pending(misc_irq_pending),
    .misc_enable(s.misc_en),
    .summary(zero_sum)
  );

  cs1_sync3 u_field_sync (
    .pclk(pclk),
    .presetn(presetn),
    .pin(field_pin),
    .level(field_q)
  );

  // Fill plus threshold reaching the depth is the same as depth minus fill at most threshold.
  assign near_full = ({1'b0, fifo_fill_count} + {2'b00, s.thr}) >= DEPTH8;
  assign near_empty = {1'b0, fifo_fill_count} <= {2'b00, s.thr};

  assign setup = psel && !penable;
  assign wr = psel && penable && pwrite && s.pready;
  assign wbyte = pstrb[0] ? pwdata[7:0] : 8'h00;

  always_comb begin
    live = 8'h00;
    live[cs1_pkg::BIT_GRP_ONE] = one_sum;
    live[cs1_pkg::BIT_CRC_GOOD] = s.crc_good;
    live[cs1_pkg::BIT_CRC_DONE] = s.crc_done;
    live[cs1_pkg::BIT_GRP_ZERO] = zero_sum;
    // The gate input is deliberately not looked at here.
    live[cs1_pkg::BIT_TIMER] = timer_enable;
    live[cs1_pkg::BIT_FIELD] = field_q;
    live[cs1_pkg::BIT_NEAR_FULL] = near_full;
    live[cs1_pkg::BIT_NEAR_EMPTY] = near_empty;
  end

  always_comb begin
    events = '0;
    events[cs1_pkg::EV_GRP_ONE] = one_sum && !s.one_d;
    events[cs1_pkg::EV_GRP_ZERO] = zero_sum && !s.zero_d;
    events[cs1_pkg::EV_CRC_DONE] = crc_finish && crc_standalone;
    events[cs1_pkg::EV_FIELD_ON] = field_q && !s.field_d;
    events[cs1_pkg::EV_FIELD_OFF] = !field_q && s.field_d;
  end

  always_comb begin
    next_s = s;
    next_s.up = 1'b1;
    next_s.one_d = one_sum;
    next_s.zero_d = zero_sum;
    next_s.field_d = field_q;
    next_s.status = live;
    // The result flag drops while calculating and shows a zero result at the end.
    if (crc_busy) begin
      next_s.crc_good = 1'b0;
    end else if (crc_finish) begin
      next_s.crc_good = crc_result_zero;
    end
    // Only a standalone compute command sets the done flag; only a new standalone calculation clears it.
    if (crc_finish && crc_standalone) begin
      next_s.crc_done = 1'b1;
    end else if (crc_busy && crc_standalone) begin
      next_s.crc_done = 1'b0;
    end
    next_s.cpu_one = one_sum && s.cpu_en[cs1_pkg::CPU_EN_GRP_ONE];
    next_s.cpu_zero = zero_sum && s.cpu_en[cs1_pkg::CPU_EN_GRP_ZERO];
    next_s.pready = setup;
    next_s.pslverr = 1'b0;
    if (setup) begin
      unique case (paddr)
        cs1_pkg::ADDR_STATUS: next_s.prdata = {24'h000000, s.status};
        cs1_pkg::ADDR_COMM_EN: next_s.prdata = {24'h000000, s.comm_en};
        cs1_pkg::ADDR_MISC_EN: next_s.prdata = {24'h000000, s.misc_en};
        cs1_pkg::ADDR_CPU_EN: next_s.prdata = {24'h000000, s.cpu_en};
        cs1_pkg::ADDR_THRESHOLD: next_s.prdata = {26'h0000000, s.thr};
        cs1_pkg::ADDR_IRQ_STATUS: next_s.prdata = {27'h0000000, s.irq_sts};
        cs1_pkg::ADDR_IRQ_CLEAR: next_s.prdata = 32'h00000000;
        cs1_pkg::ADDR_IRQ_ENABLE: next_s.prdata = {27'h0000000, s.irq_en};
        default: begin
          next_s.prdata = 32'h00000000;
          next_s.pslverr = 1'b1;
        end
      endcase
    end
    if (wr && pstrb[0]) begin
      unique case (paddr)
        cs1_pkg::ADDR_COMM_EN: next_s.comm_en = wbyte;
        cs1_pkg::ADDR_MISC_EN: next_s.misc_en = wbyte;
        cs1_pkg::ADDR_CPU_EN: next_s.cpu_en = wbyte;
        cs1_pkg::ADDR_THRESHOLD: next_s.thr = wbyte[5:0];
        cs1_pkg::ADDR_IRQ_CLEAR: next_s.irq_sts = s.irq_sts & ~wbyte[4:0];
        cs1_pkg::ADDR_IRQ_ENABLE: next_s.irq_en = wbyte[4:0];
        // Writes to the status word and read-only words are dropped.
        default: next_s.irq_sts = next_s.irq_sts;
      endcase
    end
    // A new event wins over a clear in the same cycle.
    next_s.irq_sts = next_s.irq_sts | events;
    next_s.irq = |(next_s.irq_sts & next_s.irq_en);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '0;
      s.status <= cs1_pkg::STATUS_RESET;
      s.cpu_en <= cs1_pkg::CPU_EN_RESET;
      s.thr <= cs1_pkg::THR_RESET;
      s.crc_done <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  assign prdata = s.prdata;
  assign pready = s.pready;
  assign pslverr = s.pslverr;
  assign irq = s.irq;
  assign cpu_irq_group_one = s.cpu_one;
  assign cpu_irq_group_zero = s.cpu_zero;

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  a_grp_one_flag: assert property (
    s.up |=> s.status[cs1_pkg::BIT_GRP_ONE] == $past(one_sum)
  ) else $error("Group one flag does not follow the summary.");

  a_cpu_irq_one: assert property (
    s.up && one_sum && !s.cpu_en[cs1_pkg::CPU_EN_GRP_ONE] |=> !cpu_irq_group_one
  ) else $error("Group one interrupt raised without its enable.");

  a_cpu_one_on: assert property (
    s.up && one_sum && s.cpu_en[cs1_pkg::CPU_EN_GRP_ONE] |=> cpu_irq_group_one
  ) else $error("Group one interrupt missing while enabled.");

  a_cpu_one_off: assert property (
    s.up && !one_sum |=> !cpu_irq_group_one
  ) else $error("Group one interrupt raised without a summary.");

  a_grp_zero_flag: assert property (
    s.up |=> s.status[cs1_pkg::BIT_GRP_ZERO] == $past(zero_sum)
  ) else $error("Group zero flag does not follow the summary.");

  a_cpu_irq_zero: assert property (
    s.up && zero_sum && s.cpu_en[cs1_pkg::CPU_EN_GRP_ZERO] |=> cpu_irq_group_zero
  ) else $error("Group zero interrupt missing while enabled.");

  a_cpu_zero_off: assert property (
    s.up && zero_sum && !s.cpu_en[cs1_pkg::CPU_EN_GRP_ZERO] |=> !cpu_irq_group_zero
  ) else $error("Group zero interrupt raised without its enable.");

  a_cpu_zero_idle: assert property (
    s.up && !zero_sum |=> !cpu_irq_group_zero
  ) else $error("Group zero interrupt raised without a summary.");

  a_crc_busy_low: assert property (
    crc_busy |=> !s.crc_good ##1 !s.status[cs1_pkg::BIT_CRC_GOOD]
  ) else $error("CRC result flag high during calculation.");

  a_crc_good_set: assert property (
    !crc_busy && crc_finish |=> s.crc_good == $past(crc_result_zero)
  ) else $error("CRC result flag does not show a zero result.");

  a_crc_good_flag: assert property (
    s.up |=> s.status[cs1_pkg::BIT_CRC_GOOD] == $past(s.crc_good)
  ) else $error("CRC result bit does not follow its flag.");

  a_crc_done_set: assert property (
    crc_finish && crc_standalone |=> ##1 s.status[cs1_pkg::BIT_CRC_DONE]
  ) else $error("CRC done flag not set after finish.");

  a_crc_done_clr: assert property (
    crc_busy && crc_standalone && !crc_finish |=> !s.crc_done
  ) else $error("CRC done flag not cleared by a new calculation.");

  a_crc_done_hold: assert property (
    !crc_standalone |=> s.crc_done == $past(s.crc_done)
  ) else $error("CRC done flag moved by a transfer calculation.");

  a_crc_done_flag: assert property (
    s.up |=> s.status[cs1_pkg::BIT_CRC_DONE] == $past(s.crc_done)
  ) else $error("CRC done bit does not follow its flag.");

  a_timer_flag: assert property (
    s.up |=> s.status[cs1_pkg::BIT_TIMER] == $past(timer_enable)
  ) else $error("Timer flag does not follow the enable.");

  a_gate_ignored: assert property (
    s.up && timer_gate |=> s.status[cs1_pkg::BIT_TIMER] == $past(timer_enable)
  ) else $error("Timer flag influenced by the gate.");

  a_field_direct: assert property (
    s.up && $fell(field_q) |=> !s.status[cs1_pkg::BIT_FIELD]
  ) else $error("Field flag held after the field vanished.");

  a_field_rise: assert property (
    s.up && $rose(field_q) |=> s.status[cs1_pkg::BIT_FIELD]
  ) else $error("Field flag missing after the field appeared.");

  a_field_level: assert property (
    s.up |=> s.status[cs1_pkg::BIT_FIELD] == $past(field_q)
  ) else $error("Field flag does not follow the detector.");

  a_near_full: assert property (
    s.up && $stable(fifo_fill_count) && $stable(s.thr) |=>
      s.status[cs1_pkg::BIT_NEAR_FULL] ==
      (8'(FIFO_DEPTH) - {1'b0, $past(fifo_fill_count)} <= {2'b00, $past(s.thr)})
  ) else $error("Near full flag wrong for fill and threshold.");

  a_near_empty: assert property (
    s.up && $stable(fifo_fill_count) && $stable(s.thr) |=>
      s.status[cs1_pkg::BIT_NEAR_EMPTY] == ($past(fifo_fill_count) <= {1'b0, $past(s.thr)})
  ) else $error("Near empty flag wrong for fill and threshold.");

  a_status_ro: assert property (
    wr && paddr == cs1_pkg::ADDR_STATUS |->
      !pslverr ##1 ($stable(s.comm_en) && $stable(s.misc_en) && $stable(s.cpu_en) && $stable(s.thr))
  ) else $error("Write to the status word changed state.");

  a_strobe_drop: assert property (
    wr && !pstrb[0] |=>
      $stable(s.comm_en) && $stable(s.misc_en) && $stable(s.cpu_en) && $stable(s.thr) && $stable(s.irq_en)
  ) else $error("Write without the low lane strobe changed a register.");

  a_pready_setup: assert property (
    setup |=> pready
  ) else $error("Ready missing in the first access cycle.");

  a_pready_once: assert property (
    pready |=> !pready
  ) else $error("Ready held for more than one cycle.");

  a_slverr_unmapped: assert property (
    setup && (paddr > cs1_pkg::ADDR_IRQ_ENABLE || paddr[1:0] != 2'b00) |=>
      pslverr && prdata == 32'h00000000
  ) else $error("Unmapped address answered without an error.");

  a_slverr_mapped: assert property (
    setup && paddr <= cs1_pkg::ADDR_IRQ_ENABLE && paddr[1:0] == 2'b00 |=>
      !pslverr
  ) else $error("Mapped address answered with an error.");

  a_status_read: assert property (
    setup && paddr == cs1_pkg::ADDR_STATUS |=> prdata == {24'h000000, $past(s.status)}
  ) else $error("Status read does not return the registered flags.");

  a_thr_write: assert property (
    wr && pstrb[0] && paddr == cs1_pkg::ADDR_THRESHOLD |=> s.thr == $past(pwdata[5:0])
  ) else $error("Threshold write did not land.");

  a_event_wins: assert property (
    (|events) |=> (s.irq_sts & $past(events)) == $past(events)
  ) else $error("Event lost against a clear in the same cycle.");

  a_irq_clear: assert property (
    wr && pstrb[0] && paddr == cs1_pkg::ADDR_IRQ_CLEAR |=>
      (s.irq_sts & $past(pwdata[4:0]) & ~$past(events)) == 5'h00
  ) else $error("Interrupt status bit not cleared by a written one.");

  a_irq_sticky: assert property (
    s.up && !(wr && pstrb[0] && paddr == cs1_pkg::ADDR_IRQ_CLEAR) |=>
      (s.irq_sts & $past(s.irq_sts)) == $past(s.irq_sts)
  ) else $error("Interrupt status bit dropped without a clear.");

  a_irq_level: assert property (
    irq == (|(s.irq_sts & s.irq_en))
  ) else $error("Interrupt output does not match enabled status.");

endmodule : cs1_status
`default_nettype wire

// [tb/tb_top.sv]
// Self-checking testbench for the status-one register bank over APB.
// Assumes the package and design files under logic/ are compiled first.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h00000000;
  logic [3:0] pstrb = 4'hf;
  logic [31:0] prdata;
  logic pready, pslverr, cpu_irq_group_one, cpu_irq_group_zero, irq;
  logic [7:0] comm = 8'h00, misc = 8'h00;
  logic crc_busy = 1'b0, crc_finish = 1'b0, crc_standalone = 1'b0, crc_result_zero = 1'b0;
  logic timer_enable = 1'b0, timer_gate = 1'b0, field_pin = 1'b0;
  logic [6:0] fill = 7'h00;
  logic [31:0] rdv;
  logic errv;
  int n_errors = 0;
  int comparisons = 0;
  int cyc = 0;
  cs1_status u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .comm_irq_pending(comm), .misc_irq_pending(misc), .crc_busy(crc_busy), .crc_finish(crc_finish),
    .crc_standalone(crc_standalone), .crc_result_zero(crc_result_zero), .timer_enable(timer_enable),
    .timer_gate(timer_gate), .field_pin(field_pin), .fifo_fill_count(fill),
    .cpu_irq_group_one(cpu_irq_group_one), .cpu_irq_group_zero(cpu_irq_group_zero), .irq(irq));
  always #20 pclk = ~pclk;
  // A hang is cut short here.
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      n_errors = n_errors + 1;
      report_and_stop();
    end
  end
  task automatic report_and_stop();
    if (n_errors == 0 && comparisons > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : report_and_stop
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons = comparisons + 1;
    if (got !== exp) begin
      n_errors = n_errors + 1;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // One APB transfer; entered and left just after a rising edge.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    rdv = prdata;
    errv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h00000000);
    chk(rdv, x);
  endtask : rd
  task automatic idle(input int n);
    repeat (n) @(posedge pclk);
  endtask : idle
  task automatic t_reset();
    rd(8'h00, 32'h00000021);
    rd(8'h10, 32'h00000008);
    rd(8'h0c, 32'h00000000);
    chk({29'h0, irq, cpu_irq_group_one, cpu_irq_group_zero}, 32'h0);
  endtask : t_reset
  task automatic t_readonly();
    wr(8'h00, 32'h000000de);
    chk({31'h0, errv}, 32'h0);
    rd(8'h00, 32'h00000021);
    pstrb <= 4'h0;
    wr(8'h10, 32'h0000003f);
    pstrb <= 4'hf;
    rd(8'h10, 32'h00000008);
    wr(8'hf0, 32'h000000ff);
    chk({31'h0, errv}, 32'h1);
    rd(8'hf0, 32'h00000000);
    chk({31'h0, errv}, 32'h1);
  endtask : t_readonly
  task automatic t_grp_one();
    comm <= 8'h02;
    idle(3);
    rd(8'h00, 32'h00000021);
    wr(8'h04, 32'h00000001);
    comm <= 8'h01;
    idle(3);
    rd(8'h00, 32'h000000a1);
    chk({31'h0, cpu_irq_group_one}, 32'h0);
    wr(8'h0c, 32'h00000004);
    idle(2);
    chk({31'h0, cpu_irq_group_one}, 32'h1);
    rd(8'h14, 32'h00000001);
    chk({31'h0, irq}, 32'h0);
    wr(8'h1c, 32'h00000001);
    idle(2);
    chk({31'h0, irq}, 32'h1);
    comm <= 8'h00;
    wr(8'h18, 32'h00000001);
    idle(2);
    rd(8'h14, 32'h00000000);
    chk({30'h0, irq, cpu_irq_group_one}, 32'h0);
    rd(8'h00, 32'h00000021);
  endtask : t_grp_one
  task automatic t_grp_zero();
    wr(8'h08, 32'h00000010);
    misc <= 8'h10;
    idle(3);
    rd(8'h00, 32'h00000031);
    chk({31'h0, cpu_irq_group_zero}, 32'h0);
    wr(8'h0c, 32'h00000008);
    idle(2);
    chk({30'h0, cpu_irq_group_zero, cpu_irq_group_one}, 32'h2);
    misc <= 8'h00;
    idle(3);
    rd(8'h00, 32'h00000021);
    chk({31'h0, cpu_irq_group_zero}, 32'h0);
  endtask : t_grp_zero
  task automatic t_crc();
    crc_busy <= 1'b1;
    idle(3);
    apb(1'b0, 8'h00, 32'h00000000);
    chk({31'h0, rdv[5]}, 32'h1);
    crc_busy <= 1'b0;
    crc_finish <= 1'b1;
    @(posedge pclk);
    crc_finish <= 1'b0;
    crc_busy <= 1'b1;
    crc_standalone <= 1'b1;
    idle(3);
    rd(8'h00, 32'h00000001);
    crc_busy <= 1'b0;
    crc_finish <= 1'b1;
    crc_result_zero <= 1'b1;
    @(posedge pclk);
    crc_finish <= 1'b0;
    crc_standalone <= 1'b0;
    idle(3);
    rd(8'h00, 32'h00000061);
  endtask : t_crc
  task automatic t_timer();
    timer_enable <= 1'b1;
    idle(3);
    rd(8'h00, 32'h00000069);
    timer_gate <= 1'b1;
    idle(3);
    rd(8'h00, 32'h00000069);
    timer_enable <= 1'b0;
    idle(3);
    rd(8'h00, 32'h00000061);
    timer_gate <= 1'b0;
  endtask : t_timer
  task automatic t_field();
    field_pin <= 1'b1;
    idle(7);
    rd(8'h00, 32'h00000065);
    field_pin <= 1'b0;
    idle(7);
    rd(8'h00, 32'h00000061);
  endtask : t_field
  task automatic t_fifo();
    logic [6:0] tf [6];
    logic [5:0] tt [6];
    logic [1:0] te [6];
    tf = '{7'd60, 7'd59, 7'd4, 7'd5, 7'd64, 7'd0};
    tt = '{6'd4, 6'd4, 6'd4, 6'd4, 6'd0, 6'd0};
    te = '{2'b10, 2'b00, 2'b01, 2'b00, 2'b10, 2'b01};
    for (int i = 0; i < 6; i++) begin
      wr(8'h10, {26'h0, tt[i]});
      fill <= tf[i];
      idle(3);
      apb(1'b0, 8'h00, 32'h00000000);
      chk({30'h0, rdv[1:0]}, {30'h0, te[i]});
    end
    wr(8'h10, 32'h00000008);
    fill <= 7'h00;
    idle(3);
  endtask : t_fifo
  task automatic t_events();
    rd(8'h14, 32'h0000001e);
    wr(8'h18, 32'h0000001f);
    idle(2);
    rd(8'h14, 32'h00000000);
  endtask : t_events
  task automatic t_reset_again();
    wr(8'h04, 32'h000000ff);
    presetn <= 1'b0;
    idle(2);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset();
    rd(8'h04, 32'h00000000);
  endtask : t_reset_again
  initial begin
    idle(6);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset();
    t_readonly();
    t_grp_one();
    t_grp_zero();
    t_crc();
    t_timer();
    t_field();
    t_fifo();
    t_events();
    t_reset_again();
    report_and_stop();
  end
endmodule : tb_top
`default_nettype wire
